// ### src/epoch_timing_pkg.sv
// constants for the station epoch and component divider timing
package epoch_timing_pkg;

    // =========================================================
    // timing standard and epoch periods
    // =========================================================
    localparam int STD_HZ        = 408_000;  // timing standard, counts/s
    localparam int EPOCH_S       = 30;       // common epoch period, s
    localparam int MUX_S         = 10;       // multiplex cycle, s
    localparam int TONE_CYCLES   = 34;       // lowest tone cycles per span
    localparam int TONE_SPAN_S   = 3;        // span holding those cycles, s
    localparam int EPOCH_COUNTS  = EPOCH_S * STD_HZ;
    localparam int MUX_COUNTS    = MUX_S * STD_HZ;
    localparam int MUX_PER_EPOCH = EPOCH_S / MUX_S;

    // =========================================================
    // component division ratios from the timing standard
    // =========================================================
    localparam int DIV_CARRIER_A = 40;       // 10.2 kHz
    localparam int DIV_CARRIER_B = 30;       // 13.6 kHz
    localparam int DIV_CARRIER_C = 36;       // 11-1/3 kHz
    localparam int DIV_TONE_HI   = 1_800;    // 226-2/3 Hz
    localparam int DIV_TONE_MID  = 9_000;    // 45-1/3 Hz
    localparam int DIV_TONE_LOW  =
        (TONE_SPAN_S * STD_HZ) / TONE_CYCLES; // 11-1/3 Hz
    localparam int DIV_SIDE      = 34;       // side frequency, plain default

endpackage : epoch_timing_pkg

// ### src/phase_divider.sv
// integer divider making one square wave component from the standard
`timescale 1ns/100ps

module phase_divider #(
    parameter int DIV   = 40,
    parameter int WIDTH = $clog2(DIV)
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // standard count and realignment
    input  wire logic tick,
    input  wire logic resync,
    // component output
    output logic      wave,
    output logic      wraps
);

    localparam logic [WIDTH-1:0] LAST = WIDTH'(DIV - 1);
    localparam logic [WIDTH-1:0] HALF = WIDTH'(DIV / 2);
    localparam logic [WIDTH-1:0] ZERO = '0;
    localparam logic [WIDTH-1:0] ONE  = WIDTH'(1);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // count of the next standard period; resync forces phase zero
    always_comb
    begin
        if (resync || count == LAST)
            next_count = ZERO;
        else
            next_count = count + ONE;
    end

    // wave rises as the count enters zero; reset parks at the last count
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            count <= LAST;
            wave  <= 1'b0;
            wraps <= 1'b0;
        end
        else if (tick)
        begin
            count <= next_count;
            wave  <= (next_count < HALF);
            wraps <= (next_count == ZERO);
        end
        else
            wraps <= 1'b0;
    end

endmodule : phase_divider

// ### src/station_epoch_divider_timing.sv
// station epoch counter and all signal component dividers
`timescale 1ns/100ps

// How it works
// - all components except the side divider rise through zero together at each epoch
// - epoch every 30 s, one at midnight
// - multiplex cycle of 10 s aligned to epochs
// - lowest tone makes 34 cycles per 3 s
// - carriers and tones integer multiples of lowest tone
// - every component divided from 408 kHz standard
// - side_align_pin requests the side divider be realigned to phase zero at the next epoch
// - side divider never jumps except on request
// - side frequency rises with others at midnight only if an alignment request is pending
// - side coincidence recurs every 30 times N s
// - flag epochs where side divider resets too
// - side realignment exact to one standard count
module station_epoch_divider_timing #(
    parameter int EPOCH_COUNTS = epoch_timing_pkg::EPOCH_COUNTS,
    parameter int MUX_COUNTS   = epoch_timing_pkg::MUX_COUNTS,
    parameter int DIV_TONE_MID = epoch_timing_pkg::DIV_TONE_MID,
    parameter int DIV_TONE_LOW = epoch_timing_pkg::DIV_TONE_LOW,
    parameter int DIV_SIDE     = epoch_timing_pkg::DIV_SIDE
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // timing standard and time-of-day pins
    input  wire logic std_pin,
    input  wire logic midnight_pin,
    input  wire logic side_align_pin,
    // epoch markers
    output logic      epoch_strobe,
    output logic      mux_strobe,
    output logic      side_coincident,
    output logic      align_pending,
    // signal components
    output logic      carrier_a,
    output logic      carrier_b,
    output logic      carrier_c,
    output logic      tone_hi,
    output logic      tone_mid,
    output logic      tone_low,
    output logic      side_wave
);

    localparam int EW = $clog2(EPOCH_COUNTS);
    localparam logic [EW-1:0] E_LAST = EW'(EPOCH_COUNTS - 1);
    localparam logic [EW-1:0] E_ZERO = '0;
    localparam logic [EW-1:0] E_ONE  = EW'(1);
    localparam logic [EW-1:0] M_ONE  = EW'(MUX_COUNTS);
    localparam logic [EW-1:0] M_TWO  = EW'(2 * MUX_COUNTS);

    // =========================================================
    // pin synchronisers and standard edge
    // =========================================================
    logic [1:0] std_sync;
    logic [1:0] mid_sync;
    logic [1:0] align_sync;
    logic       std_last;
    logic       mid_last;
    logic       align_last;
    logic       tick;
    logic       mid_rise;
    logic       align_rise;

    // two flops per pin before any logic reads it
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            std_sync   <= 2'h0;
            mid_sync   <= 2'h0;
            align_sync <= 2'h0;
        end
        else
        begin
            std_sync   <= {std_sync[0], std_pin};
            mid_sync   <= {mid_sync[0], midnight_pin};
            align_sync <= {align_sync[0], side_align_pin};
        end
    end

    // edge history on the synchronised stage only
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            std_last   <= 1'b0;
            mid_last   <= 1'b0;
            align_last <= 1'b0;
        end
        else
        begin
            std_last   <= std_sync[1];
            mid_last   <= mid_sync[1];
            align_last <= align_sync[1];
        end
    end

    // one standard count per rising edge of the 408 kHz input
    assign tick       = std_sync[1] & ~std_last;
    assign mid_rise   = mid_sync[1] & ~mid_last;
    assign align_rise = align_sync[1] & ~align_last;

    // =========================================================
    // master epoch counter
    // =========================================================
    logic [EW-1:0] epoch_count;
    logic [EW-1:0] next_epoch_count;
    logic          mid_pending;
    logic          epoch_tick;

    // midnight forces the next count to phase zero of an epoch
    always_comb
    begin
        if (mid_pending || epoch_count == E_LAST)
            next_epoch_count = E_ZERO;
        else
            next_epoch_count = epoch_count + E_ONE;
    end

    assign epoch_tick = tick && (next_epoch_count == E_ZERO);

    // hold a midnight mark until the next standard count
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            mid_pending <= 1'b0;
        else if (mid_rise)
            mid_pending <= 1'b1;                     // set wins over clear
        else if (tick)
            mid_pending <= 1'b0;
    end

    // 30 s count of the standard; reset parks at the last count
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            epoch_count <= E_LAST;
        else if (tick)
            epoch_count <= next_epoch_count;
    end

    // one-cycle epoch and multiplex strobes
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            epoch_strobe <= 1'b0;
            mux_strobe   <= 1'b0;
        end
        else
        begin
            epoch_strobe <= epoch_tick;
            mux_strobe   <= tick && (next_epoch_count == E_ZERO
                         || next_epoch_count == M_ONE
                         || next_epoch_count == M_TWO);
        end
    end

    // =========================================================
    // component dividers, each pulled to zero at every epoch
    // =========================================================
    // epochs are whole multiples of every ratio, so this
    // resync never moves a healthy divider
    phase_divider #(.DIV(epoch_timing_pkg::DIV_CARRIER_A)) u_carrier_a (
        .clock (clock), .rst (rst), .tick (tick),
        .resync (epoch_tick), .wave (carrier_a), .wraps ()
    );

    phase_divider #(.DIV(epoch_timing_pkg::DIV_CARRIER_B)) u_carrier_b (
        .clock (clock), .rst (rst), .tick (tick),
        .resync (epoch_tick), .wave (carrier_b), .wraps ()
    );

    phase_divider #(.DIV(epoch_timing_pkg::DIV_CARRIER_C)) u_carrier_c (
        .clock (clock), .rst (rst), .tick (tick),
        .resync (epoch_tick), .wave (carrier_c), .wraps ()
    );

    phase_divider #(.DIV(epoch_timing_pkg::DIV_TONE_HI)) u_tone_hi (
        .clock (clock), .rst (rst), .tick (tick),
        .resync (epoch_tick), .wave (tone_hi), .wraps ()
    );

    phase_divider #(.DIV(DIV_TONE_MID)) u_tone_mid (
        .clock (clock), .rst (rst), .tick (tick),
        .resync (epoch_tick), .wave (tone_mid), .wraps ()
    );

    // 36000 counts: exactly 34 cycles in each 3 s
    phase_divider #(.DIV(DIV_TONE_LOW)) u_tone_low (
        .clock (clock), .rst (rst), .tick (tick),
        .resync (epoch_tick), .wave (tone_low), .wraps ()
    );

    // =========================================================
    // side frequency divider and its alignment
    // =========================================================
    logic side_resync;
    logic side_wraps;

    // realign only on request, and only at an epoch count
    assign side_resync = align_pending && epoch_tick;

    // an alignment request waits for the next epoch
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            align_pending <= 1'b0;
        else if (align_rise)
            align_pending <= 1'b1;
        else if (side_resync)
            align_pending <= 1'b0;
    end

    // free-running otherwise, so phase stays continuous
    phase_divider #(.DIV(DIV_SIDE)) u_side (
        .clock  (clock),
        .rst    (rst),
        .tick   (tick),
        .resync (side_resync),
        .wave   (side_wave),
        .wraps  (side_wraps)
    );

    // side wrap on the same count as an epoch: at most every 30*N s
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            side_coincident <= 1'b0;
        else
            side_coincident <= side_wraps && epoch_strobe;
    end
    // epoch_strobe and side_wraps are both registered on the same tick,
    // so the flag lands one clock after them

endmodule : station_epoch_divider_timing

// ### dv/std_source.sv
// timing standard source feeding the epoch block
`timescale 1ns/100ps

module std_source (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // standard pin and count of rises sent
    output logic      std_pin,
    output int        sent
);
    // =========================================================
    // one standard count every four clocks, two high, two low
    // =========================================================
    logic [1:0] phase;

    // single source for every component division
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            phase   <= 2'h0;
            std_pin <= 1'b0;
            sent    <= 0;
        end
        else
        begin
            phase   <= phase + 2'h1;
            std_pin <= (phase == 2'h1) || (phase == 2'h2);
            if (phase == 2'h1)
                sent <= sent + 1;
        end
    end
endmodule : std_source

// ### dv/epoch_props.sv
// checker for the epoch markers and component phase
`timescale 1ns/100ps

module epoch_props (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // markers
    input wire logic epoch_strobe,
    input wire logic mux_strobe,
    input wire logic side_coincident,
    input wire logic align_pending,
    // waves
    input wire logic carrier_a,
    input wire logic carrier_b,
    input wire logic carrier_c,
    input wire logic tone_hi,
    input wire logic tone_mid,
    input wire logic tone_low,
    input wire logic side_wave
);
    // =========================================================
    // marker and wave relations
    // =========================================================
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    epoch_pulse_a: assert property (epoch_strobe |=> !epoch_strobe)
        else $error("epoch strobe longer than one clock");
    epoch_mux_a: assert property (epoch_strobe |-> mux_strobe)
        else $error("epoch without multiplex start");
    mux_pulse_a: assert property (mux_strobe |=> !mux_strobe)
        else $error("multiplex strobe longer than one clock");
    epoch_waves_a: assert property (epoch_strobe |-> carrier_a &&
        carrier_b && carrier_c && tone_hi && tone_mid && tone_low)
        else $error("component low at epoch");
    tone_lock_a: assert property ($rose(tone_low) |-> carrier_a &&
        carrier_b && carrier_c && tone_mid)
        else $error("lowest tone rise without carriers");
    mux_align_a: assert property (mux_strobe |-> carrier_a && carrier_b)
        else $error("multiplex start off carrier phase");
    side_flag_a: assert property (side_coincident |->
        $past(epoch_strobe) && side_wave)
        else $error("side flag without epoch");
    align_clear_a: assert property ($fell(align_pending) |->
        epoch_strobe && side_wave)
        else $error("alignment cleared off epoch");
    align_hold_a: assert property (align_pending |=>
        align_pending || epoch_strobe)
        else $error("alignment dropped before epoch");

    cover property (epoch_strobe);
    cover property (side_coincident);
    cover property ($fell(align_pending));
endmodule : epoch_props

bind station_epoch_divider_timing epoch_props chk (
    .clock(clock), .rst(rst), .epoch_strobe(epoch_strobe),
    .mux_strobe(mux_strobe), .side_coincident(side_coincident),
    .align_pending(align_pending), .carrier_a(carrier_a),
    .carrier_b(carrier_b), .carrier_c(carrier_c), .tone_hi(tone_hi),
    .tone_mid(tone_mid), .tone_low(tone_low), .side_wave(side_wave)
);

// ### dv/tb_top.sv
// testbench for the station epoch divider timing block
`timescale 1ns/100ps

module tb_top;
    // =========================================================
    // signals and shortened counts
    // =========================================================
    localparam int EP = 1800;
    localparam int LOW = 360;
    logic clock, rst, std_pin, midnight_pin, side_align_pin;
    logic epoch_strobe, mux_strobe, side_coincident, align_pending;
    logic carrier_a, carrier_b, carrier_c, tone_hi, tone_mid;
    logic tone_low, side_wave;
    int   sent, err_total, checked, tk, mx, lo, ca, t0;
    logic sc;

    std_source src (.clock(clock), .rst(rst), .std_pin(std_pin),
        .sent(sent));
    station_epoch_divider_timing #(.EPOCH_COUNTS(EP), .MUX_COUNTS(600),
        .DIV_TONE_MID(90), .DIV_TONE_LOW(LOW), .DIV_SIDE(7)) dut (
        .clock(clock), .rst(rst), .std_pin(std_pin),
        .midnight_pin(midnight_pin), .side_align_pin(side_align_pin),
        .epoch_strobe(epoch_strobe), .mux_strobe(mux_strobe),
        .side_coincident(side_coincident), .align_pending(align_pending),
        .carrier_a(carrier_a), .carrier_b(carrier_b),
        .carrier_c(carrier_c), .tone_hi(tone_hi), .tone_mid(tone_mid),
        .tone_low(tone_low), .side_wave(side_wave));

    always #10 clock = ~clock;

    // =========================================================
    // shared tasks
    // =========================================================
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check

    // one clock, sampled once the edge has settled
    task automatic step(input int n);
        int guard;
        guard = n;
        step_wait: begin
            @(posedge clock);
            #1;
        end
        if (guard > 8000)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask : step

    // one epoch interval counted from just after an epoch strobe
    task automatic run_epoch;
        logic pl, pa;
        int   n;
        {mx, lo, ca, n} = '0;
        {pl, pa} = {tone_low, carrier_a};
        do
        begin
            n++;
            step(n);
            mx += int'(mux_strobe === 1'b1);
            lo += int'(tone_low === 1'b1 && !pl);
            ca += int'(carrier_a === 1'b1 && !pa);
            {pl, pa} = {tone_low, carrier_a};
        end while (epoch_strobe !== 1'b1);
        tk = sent - t0;
        t0 = sent;
        step(0);
        sc = side_coincident;
    endtask : run_epoch

    // =========================================================
    // scenarios
    // =========================================================
    task automatic s_reset_epoch;
        int n;
        n = 0;
        do
        begin
            n++;
            step(n);
        end while (epoch_strobe !== 1'b1);
        t0 = sent;
        check("waves", {carrier_a, carrier_b, carrier_c, tone_hi, tone_mid,
            tone_low, side_wave}, 32'h0000_007F);
        check("mux", mux_strobe, 1'b1);
        step(0);
        check("side flag", side_coincident, 1'b1);
    endtask : s_reset_epoch

    task automatic s_spacing;
        run_epoch();
        check("ticks", tk, EP);
        check("mux count", mx, 3);
        check("low tone", lo, EP / LOW);
        check("carrier", ca, EP / 40);
        check("side flag", sc, 1'b0);
    endtask : s_spacing

    task automatic s_align;
        @(posedge clock);
        side_align_pin <= 1'b1;
        repeat (4) @(posedge clock);
        side_align_pin <= 1'b0;
        step(0);
        check("pending", align_pending, 1'b1);
        run_epoch();
        check("ticks", tk, EP);
        check("side flag", sc, 1'b1);
        check("pending", align_pending, 1'b0);
    endtask : s_align

    task automatic s_recur;
        int sum, hits;
        {sum, hits} = '0;
        repeat (7)
        begin
            run_epoch();
            sum += tk;
            hits += int'(sc === 1'b1);
        end
        check("ticks", sum, 7 * EP);
        check("side hits", hits, 1);
        check("last side", sc, 1'b1);
    endtask : s_recur

    task automatic s_midnight;
        repeat (2000) @(posedge clock);
        midnight_pin <= 1'b1;
        t0 = sent;
        repeat (4) @(posedge clock);
        midnight_pin <= 1'b0;
        for (int n = 1; epoch_strobe !== 1'b1; n++)
            step(n);
        check("early", int'(sent - t0 <= 2), 1);
        check("waves", {carrier_a, carrier_c, tone_low}, 3'h7);
        t0 = sent;
        step(0);
        run_epoch();
        check("ticks", tk, EP);
    endtask : s_midnight

    // =========================================================
    // main sequence
    // =========================================================
    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        midnight_pin = 1'b0;
        side_align_pin = 1'b0;
        err_total = 0;
        checked = 0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        s_reset_epoch();
        s_spacing();
        s_align();
        s_recur();
        s_midnight();
        tally_and_finish();
    end
endmodule : tb_top
